// [logic/msir_pkg.sv]
// Constants, types and register map of the magnetic sensor register readout
package msir_pkg;
  // Register offsets
  localparam logic [7:0] MSIR_X_HI = 8'h00;
  localparam logic [7:0] MSIR_X_MID = 8'h01;
  localparam logic [7:0] MSIR_Y_HI = 8'h02;
  localparam logic [7:0] MSIR_Y_MID = 8'h03;
  localparam logic [7:0] MSIR_Z_HI = 8'h04;
  localparam logic [7:0] MSIR_Z_MID = 8'h05;
  localparam logic [7:0] MSIR_X_LO = 8'h06;
  localparam logic [7:0] MSIR_Y_LO = 8'h07;
  localparam logic [7:0] MSIR_Z_LO = 8'h08;
  localparam logic [7:0] MSIR_TEMP = 8'h09;
  localparam logic [7:0] MSIR_STATUS = 8'h18;
  localparam logic [7:0] MSIR_OUT_RATE = 8'h1A;
  localparam logic [7:0] MSIR_CTRL0 = 8'h1B;
  localparam logic [7:0] MSIR_CTRL1 = 8'h1C;
  localparam logic [7:0] MSIR_CTRL2 = 8'h1D;
  localparam logic [7:0] MSIR_THR_X = 8'h1E;
  localparam logic [7:0] MSIR_THR_Y = 8'h1F;
  localparam logic [7:0] MSIR_THR_Z = 8'h20;
  localparam logic [7:0] MSIR_CHK_X = 8'h27;
  localparam logic [7:0] MSIR_CHK_Y = 8'h28;
  localparam logic [7:0] MSIR_CHK_Z = 8'h29;
  localparam logic [7:0] MSIR_PART_ID = 8'h39;
  // Status field positions
  localparam int MSIR_ST_TEMP_BIT = 7;
  localparam int MSIR_ST_MAG_BIT = 6;
  // Values after reset
  localparam logic [7:0] MSIR_REG_RST = 8'h00;
  localparam logic [2:0] MSIR_PIN_RST = 3'h7;
  // Default bus address of the slave
  localparam logic [6:0] MSIR_DEV_ADDR_DEF = 7'h30;
  // Precision mode codes
  localparam logic [1:0] MSIR_MODE16 = 2'h0;
  localparam logic [1:0] MSIR_MODE18 = 2'h1;
  localparam logic [1:0] MSIR_MODE20 = 2'h2;
  // Bits per byte, counted on the clock line
  localparam logic [3:0] MSIR_BYTE_BITS = 4'h8;
  localparam logic [3:0] MSIR_LAST_BIT = 4'h7;

  typedef enum logic [3:0] {
    MSIR_IDLE, MSIR_ADDR, MSIR_ADDR_ACK, MSIR_REG, MSIR_REG_ACK,
    MSIR_WDATA, MSIR_WACK, MSIR_RDATA, MSIR_RACK
  } msir_state_e;

  typedef struct packed {
    logic [19:0] x;
    logic [19:0] y;
    logic [19:0] z;
  } msir_axes_s;

  typedef struct packed {
    logic [7:0] out_rate;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
  } msir_cfg_s;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } msir_trip_s;
endpackage

// [logic/msir_regs.sv]
// Two-wire slave with the register bank of the magnetic sensor
// What this block does
// - Acts only as slave; answers only transfers addressed to it.
// - Lines are only pulled low or released; pull-ups make the high.
// - Data changes only while the clock line is low.
// - Axis results are plain unsigned binary.
// - Precision 16, 18 or 20 bits keeps bits 19:4, 19:2 or 19:0.
// - Result split: 19:12 high byte, 11:4 middle, 3:0 in upper nibble.
// - High/middle bytes at 00H-05H by axis; low nibbles at 06H-08H.
// - Check values at 27H-29H, check thresholds at 1EH-20H.
// - Magnetic done flag clears only when an axis byte is read.
`timescale 1ns/1ps
module msir_regs
  import msir_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = msir_pkg::MSIR_DEV_ADDR_DEF,
  // Arbitrary part code
  parameter logic [7:0] PART_CODE = 8'h5A
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Measurement side
  input wire msir_pkg::msir_axes_s axes,
  input wire logic [7:0] temp,
  input wire logic [1:0] prec_mode,
  input wire logic mag_done_set,
  input wire logic temp_done_set,
  // Configuration and status
  output msir_pkg::msir_cfg_s cfg,
  output msir_pkg::msir_trip_s thr,
  output msir_pkg::msir_trip_s chk,
  output logic mag_done,
  output logic temp_done
);
  import msir_pkg::*;

  if (DEV_ADDR > 7'h77 || DEV_ADDR < 7'h08) begin : g_chk
    $error("DEV_ADDR lies in a reserved range");
  end

  logic [2:0] scl_s_r, sda_s_r;
  logic scl_f_r, sda_f_r, scl_q_r, sda_q_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  msir_state_e state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, rd_val;
  logic rw_r, oe_r, load_en, wr_en;
  logic rd_clr_mag, rd_clr_tmp;
  logic [19:0] xm, ym, zm;

  // Three-stage pin sync; level accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s_r <= MSIR_PIN_RST;
      sda_s_r <= MSIR_PIN_RST;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (ce) begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_q_r <= scl_f_r;
      sda_q_r <= sda_f_r;
    end
  end

  assign scl_rise = scl_f_r & ~scl_q_r;
  assign scl_fall = ~scl_f_r & scl_q_r;
  assign start_c = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;
  assign stop_c = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;

  assign load_en = scl_fall && ((state_r == MSIR_ADDR_ACK && rw_r) || state_r == MSIR_RACK);
  assign wr_en = scl_fall && state_r == MSIR_WDATA && cnt_r == MSIR_BYTE_BITS;
  assign rd_clr_mag = load_en && ptr_r <= MSIR_Z_LO;
  assign rd_clr_tmp = load_en && ptr_r == MSIR_TEMP;

  // Precision masking of unsigned results
  function automatic logic [19:0] prec(input logic [19:0] v, input logic [1:0] m);
    logic [19:0] r;
    r = v;
    if (m == MSIR_MODE16) begin
      r[3:0] = 4'h0;
    end else if (m == MSIR_MODE18) begin
      r[1:0] = 2'h0;
    end
    return r;
  endfunction

  assign xm = prec(axes.x, prec_mode);
  assign ym = prec(axes.y, prec_mode);
  assign zm = prec(axes.z, prec_mode);

  // Read mux; write-only and unmapped locations read zero
  always_comb begin
    case (ptr_r)
      MSIR_X_HI: rd_val = xm[19:12];
      MSIR_X_MID: rd_val = xm[11:4];
      MSIR_Y_HI: rd_val = ym[19:12];
      MSIR_Y_MID: rd_val = ym[11:4];
      MSIR_Z_HI: rd_val = zm[19:12];
      MSIR_Z_MID: rd_val = zm[11:4];
      MSIR_X_LO: rd_val = {xm[3:0], 4'h0};
      MSIR_Y_LO: rd_val = {ym[3:0], 4'h0};
      MSIR_Z_LO: rd_val = {zm[3:0], 4'h0};
      MSIR_TEMP: rd_val = temp;
      MSIR_STATUS: begin
        rd_val = 8'h00;
        rd_val[MSIR_ST_TEMP_BIT] = temp_done;
        rd_val[MSIR_ST_MAG_BIT] = mag_done;
      end
      MSIR_THR_X: rd_val = thr.x;
      MSIR_THR_Y: rd_val = thr.y;
      MSIR_THR_Z: rd_val = thr.z;
      MSIR_CHK_X: rd_val = chk.x;
      MSIR_CHK_Y: rd_val = chk.y;
      MSIR_CHK_Z: rd_val = chk.z;
      MSIR_PART_ID: rd_val = PART_CODE;
      default: rd_val = 8'h00;
    endcase
  end

  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= MSIR_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (ce) begin
      if (start_c) begin
        state_r <= MSIR_ADDR;
        cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= MSIR_IDLE;
        oe_r <= 1'b0;
      end else begin
        if (load_en) begin
          tx_r <= rd_val;
          ptr_r <= ptr_r + 8'h01;
          oe_r <= ~rd_val[7];
          cnt_r <= 4'h0;
        end
        case (state_r)
          MSIR_ADDR, MSIR_REG, MSIR_WDATA: begin
            if (scl_rise && cnt_r != MSIR_BYTE_BITS) begin
              sh_r <= {sh_r[6:0], sda_f_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == MSIR_BYTE_BITS) begin
              cnt_r <= 4'h0;
              if (state_r == MSIR_ADDR) begin
                if (sh_r[7:1] == DEV_ADDR) begin
                  rw_r <= sh_r[0];
                  oe_r <= 1'b1;
                  state_r <= MSIR_ADDR_ACK;
                end else begin
                  state_r <= MSIR_IDLE;
                end
              end else if (state_r == MSIR_REG) begin
                ptr_r <= sh_r;
                oe_r <= 1'b1;
                state_r <= MSIR_REG_ACK;
              end else begin
                ptr_r <= ptr_r + 8'h01;
                oe_r <= 1'b1;
                state_r <= MSIR_WACK;
              end
            end
          end
          MSIR_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                state_r <= MSIR_RDATA;
              end else begin
                oe_r <= 1'b0;
                state_r <= MSIR_REG;
              end
            end
          end
          MSIR_REG_ACK, MSIR_WACK: begin
            if (scl_fall) begin
              oe_r <= 1'b0;
              state_r <= MSIR_WDATA;
            end
          end
          MSIR_RDATA: begin
            if (scl_fall) begin
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == MSIR_LAST_BIT) begin
                oe_r <= 1'b0;
                state_r <= MSIR_RACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                oe_r <= ~tx_r[6];
              end
            end
          end
          MSIR_RACK: begin
            if (scl_rise && sda_f_r) begin
              state_r <= MSIR_IDLE;
            end else if (scl_fall) begin
              state_r <= MSIR_RDATA;
            end
          end
          default: state_r <= MSIR_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;

  // Writable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= '0;
      thr <= '0;
      chk <= '0;
    end else if (ce && wr_en) begin
      case (ptr_r)
        MSIR_OUT_RATE: cfg.out_rate <= sh_r;
        MSIR_CTRL0: cfg.ctrl0 <= sh_r;
        MSIR_CTRL1: cfg.ctrl1 <= sh_r;
        MSIR_CTRL2: cfg.ctrl2 <= sh_r;
        MSIR_THR_X: thr.x <= sh_r;
        MSIR_THR_Y: thr.y <= sh_r;
        MSIR_THR_Z: thr.z <= sh_r;
        MSIR_CHK_X: chk.x <= sh_r;
        MSIR_CHK_Y: chk.y <= sh_r;
        MSIR_CHK_Z: chk.z <= sh_r;
        default: cfg <= cfg;
      endcase
    end
  end

  // Done flags; a new result wins over a clearing read
  always_ff @(posedge clk) begin
    if (rst) begin
      mag_done <= 1'b0;
      temp_done <= 1'b0;
    end else if (ce) begin
      mag_done <= mag_done_set | (mag_done & ~rd_clr_mag);
      temp_done <= temp_done_set | (temp_done & ~rd_clr_tmp);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  // Pin is only ever pulled low, and only in the phases where the slave answers
  property p_open_drain;
    sda_oe |-> sda_out == 1'b0 &&
      state_r inside {MSIR_ADDR_ACK, MSIR_REG_ACK, MSIR_WACK, MSIR_RDATA};
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda pulled outside answer");

  property p_slave_only;
    state_r == MSIR_IDLE && $past(state_r) == MSIR_IDLE |-> !sda_oe;
  endproperty
  a_slave_only: assert property (p_slave_only) else $error("sda pulled while idle");

  property p_data_stable;
    $changed(sda_oe) |-> !scl_f_r;
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("sda moved in clock high");

  property p_mode16;
    load_en && ptr_r == MSIR_X_LO && prec_mode == MSIR_MODE16 |=> tx_r == 8'h00;
  endproperty
  a_mode16: assert property (p_mode16) else $error("16-bit low nibble not zero");

  property p_low_nibble;
    load_en && ptr_r == MSIR_Y_LO |=> tx_r[3:0] == 4'h0 && tx_r[7:4] == $past(ym[3:0]);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("low nibble byte wrong");

  property p_x_high;
    load_en && ptr_r == MSIR_X_HI |=> tx_r == $past(xm[19:12]);
  endproperty
  a_x_high: assert property (p_x_high) else $error("x high byte wrong");

  property p_check_write;
    wr_en && ptr_r == MSIR_CHK_Z |=> chk.z == $past(sh_r) ##1 ptr_r != MSIR_CHK_Z;
  endproperty
  a_check_write: assert property (p_check_write) else $error("check value write lost");

  property p_mag_clear;
    mag_done && !mag_done_set && !rd_clr_mag |=> mag_done;
  endproperty
  a_mag_clear: assert property (p_mag_clear) else $error("done flag dropped");

  property p_ptr_step;
    load_en |=> ptr_r == $past(ptr_r) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not advance");

  c_read: cover property (load_en && state_r == MSIR_ADDR_ACK);
  c_burst: cover property (load_en && state_r == MSIR_RACK);
  c_write: cover property (wr_en);
  c_clear: cover property (rd_clr_mag && mag_done);
endmodule

// [verification/msir_bus_master.sv]
// Two-wire bus master model driving the sensor's clock and data pins
`timescale 1ns/1ps
module msir_bus_master (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic sda_oe,
  output logic scl_pin,
  output logic sda_pin
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Only pulls low; pull-ups make the high level
  assign scl_pin = !scl_low;
  assign sda_pin = !(sda_low || sda_oe);
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bus is released, then seen idle before data falls
  task automatic start();
    sda_low = 1'b0;
    wt(8);
    scl_low = 1'b0;
    wt(8);
    sda_low = 1'b1;
    wt(8);
    scl_low = 1'b1;
  endtask
  task automatic clock_bit(input logic b, output logic r);
    wt(4);
    sda_low = !b;
    wt(4);
    scl_low = 1'b0;
    wt(8);
    r = sda_pin;
    scl_low = 1'b1;
  endtask
  // Address byte is 7 bits and direction, MSB first
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, r);
      d[i] = r;
    end
    clock_bit(!more, r);
  endtask
  task automatic stop();
    wt(4);
    sda_low = 1'b1;
    wt(4);
    scl_low = 1'b0;
    wt(8);
    sda_low = 1'b0;
    wt(8);
  endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the sensor register readout
`timescale 1ns/1ps
module tb;
  import msir_pkg::*;
  // Arbitrary part code
  localparam logic [7:0] PART = 8'hC3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic scl_pin;
  logic sda_pin;
  logic sda_out;
  logic sda_oe;
  msir_axes_s axes = {20'hFEDCB, 20'h8A5C7, 20'h13579};
  logic [7:0] temp = 8'h9E;
  logic [1:0] prec_mode = 2'h0;
  logic mag_done_set = 1'b0;
  logic temp_done_set = 1'b0;
  msir_cfg_s cfg;
  msir_trip_s thr;
  msir_trip_s chk;
  logic mag_done;
  logic temp_done;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] rd [$];
  initial begin
    forever #10 clk = ~clk;
  end
  msir_regs #(.DEV_ADDR(MSIR_DEV_ADDR_DEF), .PART_CODE(PART)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_pin), .sda_in(sda_pin),
    .sda_out(sda_out), .sda_oe(sda_oe), .axes(axes), .temp(temp),
    .prec_mode(prec_mode), .mag_done_set(mag_done_set),
    .temp_done_set(temp_done_set), .cfg(cfg), .thr(thr), .chk(chk),
    .mag_done(mag_done), .temp_done(temp_done)
  );
  msir_bus_master master (.clk(clk), .sda_oe(sda_oe), .scl_pin(scl_pin), .sda_pin(sda_pin));
  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
    logic ack;
    master.start();
    master.send({MSIR_DEV_ADDR_DEF, 1'b0}, ack);
    cmp1(ack, 1'b1, "write address ack");
    master.send(a, ack);
    cmp1(ack, 1'b1, "pointer ack");
    foreach (d[i]) begin
      master.send(d[i], ack);
      cmp1(ack, 1'b1, "data ack");
    end
    master.stop();
  endtask
  task automatic rdn(input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] b;
    rd = {};
    master.start();
    master.send({MSIR_DEV_ADDR_DEF, 1'b0}, ack);
    master.send(a, ack);
    master.start();
    master.send({MSIR_DEV_ADDR_DEF, 1'b1}, ack);
    cmp1(ack, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      master.recv(i < n - 1, b);
      rd.push_back(b);
    end
    master.stop();
  endtask
  function automatic logic [19:0] keep(input logic [19:0] v, input int m);
    return m == 0 ? {v[19:4], 4'h0} : m == 1 ? {v[19:2], 2'h0} : v;
  endfunction
  task automatic s_reset();
    rdn(MSIR_THR_X, 3);
    foreach (rd[i]) begin
      cmp8(rd[i], 8'h00, "threshold after reset");
    end
    rdn(MSIR_STATUS, 1);
    cmp8(rd[0], 8'h00, "status after reset");
  endtask
  task automatic s_axes();
    logic [19:0] v [3];
    for (int m = 0; m < 4; m++) begin
      prec_mode = m[1:0];
      v = '{keep(axes.x, m), keep(axes.y, m), keep(axes.z, m)};
      rdn(MSIR_X_HI, 9);
      for (int a = 0; a < 3; a++) begin
        cmp8(rd[2 * a], v[a][19:12], "axis high");
        cmp8(rd[2 * a + 1], v[a][11:4], "axis mid");
        cmp8(rd[6 + a], {v[a][3:0], 4'h0}, "axis low");
      end
    end
  endtask
  task automatic s_config();
    wr(MSIR_THR_X, '{8'h11, 8'h22, 8'h33});
    wr(MSIR_CHK_X, '{8'h44, 8'h55, 8'h66});
    wr(MSIR_OUT_RATE, '{8'h01, 8'h02, 8'h03, 8'h04});
    cmp8(thr.x, 8'h11, "thr x");
    cmp8(thr.y, 8'h22, "thr y");
    cmp8(thr.z, 8'h33, "thr z");
    cmp8(chk.x, 8'h44, "chk x");
    cmp8(chk.y, 8'h55, "chk y");
    cmp8(chk.z, 8'h66, "chk z");
    cmp8(cfg.out_rate, 8'h01, "rate");
    cmp8(cfg.ctrl0, 8'h02, "ctrl0");
    cmp8(cfg.ctrl1, 8'h03, "ctrl1");
    cmp8(cfg.ctrl2, 8'h04, "ctrl2");
    rdn(MSIR_CHK_X, 3);
    cmp8(rd[0], 8'h44, "chk x read");
    cmp8(rd[2], 8'h66, "chk z read");
    rdn(MSIR_OUT_RATE, 1);
    cmp8(rd[0], 8'h00, "write-only read");
    rdn(MSIR_PART_ID, 1);
    cmp8(rd[0], PART, "part code");
  endtask
  task automatic s_status();
    // A result pulse while frozen must leave the flag untouched
    ce = 1'b0;
    mag_done_set = 1'b1;
    @(negedge clk);
    mag_done_set = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    cmp1(mag_done, 1'b0, "flag set while frozen");
    mag_done_set = 1'b1;
    temp_done_set = 1'b1;
    @(negedge clk);
    mag_done_set = 1'b0;
    temp_done_set = 1'b0;
    @(negedge clk);
    rdn(MSIR_STATUS, 1);
    cmp8(rd[0], 8'hC0, "status set");
    rdn(MSIR_PART_ID, 1);
    cmp1(mag_done, 1'b1, "flag kept on other read");
    rdn(MSIR_Y_LO, 1);
    cmp1(mag_done, 1'b0, "flag cleared by axis read");
    cmp1(temp_done, 1'b1, "temp flag kept");
    rdn(MSIR_TEMP, 1);
    cmp8(rd[0], 8'h9E, "temperature");
    cmp1(temp_done, 1'b0, "temp flag cleared");
  endtask
  task automatic s_wrong_addr();
    logic ack;
    master.start();
    master.send({MSIR_DEV_ADDR_DEF ^ 7'h01, 1'b1}, ack);
    cmp1(ack, 1'b0, "foreign address");
    master.stop();
    cmp1(sda_oe, 1'b0, "data pin held after foreign address");
    cmp1(sda_out, 1'b0, "data pin driven high");
    rdn(MSIR_THR_Y, 1);
    cmp8(rd[0], 8'h22, "after foreign address");
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_axes();
    s_config();
    s_status();
    s_wrong_addr();
    finish_test();
  end
endmodule
